// ---- core/edac_pkg.sv ----
package edac_pkg;

  // Store geometry
  localparam int unsigned DEPTH = 64;
  localparam int unsigned AW    = 6;
  localparam int unsigned DW    = 8;

  // Special register locations and banks
  localparam logic [7:0] IDX_OFS     = 8'h3A;
  localparam logic [7:0] BUF_OFS     = 8'h3B;
  localparam logic [7:0] CTL_OFS     = 8'h40;
  localparam logic       BANK_CTL    = 1'b1;

  // Control field positions and reset values
  localparam int unsigned WRITE_ENABLE_BIT_BIT   = 3;
  localparam int unsigned WR_BIT     = 2;
  localparam int unsigned READ_ENABLE_BIT_BIT   = 1;
  localparam int unsigned RD_BIT     = 0;
  localparam logic       CTL_RST     = 1'b0;
  localparam logic [5:0] IDX_RST     = 6'h00;
  localparam logic [7:0] BUF_RST     = 8'h00;

  // Timing
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned TICK_NS       = 1000;
  localparam int unsigned TICK_CYC      =
    (TICK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WR_TIME_US    = 2000;
  localparam int unsigned WR_TICKS      = WR_TIME_US * 1000 / TICK_NS;
  localparam int unsigned RD_TIME_NS    = 16;
  localparam int unsigned RD_CYC        =
    (RD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [1:0]  RD_LAST       = 2'(RD_CYC - 1);

  // Access sequencer states
  typedef enum logic [1:0] {
    EDAC_IDLE,
    EDAC_READ,
    EDAC_WRITE
  } edac_state_e;

endpackage : edac_pkg

// ---- core/edac_store.sv ----
`timescale 1ns/100ps
module edac_store (
  input  wire logic                  sys_clk_i, // System clock
  input  wire logic                  we_i,      // Write strobe
  input  wire logic                  re_i,      // Read strobe
  input  wire logic [edac_pkg::AW-1:0] addr_i,  // Location
  input  wire logic [edac_pkg::DW-1:0] wdata_i, // Byte to store
  output logic      [edac_pkg::DW-1:0] rdata_o  // Fetched byte
);

  // Non-volatile array, no reset by nature
  logic [edac_pkg::DW-1:0] mem_q [edac_pkg::DEPTH];
  logic [edac_pkg::DW-1:0] rdata_q;

  // One byte per access, 64 locations
  always_ff @(posedge sys_clk_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    if (re_i) begin
      rdata_q <= mem_q[addr_i];
    end
  end

  assign rdata_o = rdata_q;

endmodule : edac_store

// ---- core/edac_wr_timer.sv ----
`timescale 1ns/100ps
module edac_wr_timer #(
  parameter int unsigned WR_TICKS = edac_pkg::WR_TICKS
) (
  input  wire logic sys_clk_i, // System clock
  input  wire logic rst_n_i,   // Sync reset, active low
  input  wire logic start_i,   // Begin a write delay
  output logic      done_o     // One-cycle end pulse
);

  localparam logic [7:0]  PRE_LAST  = 8'(edac_pkg::TICK_CYC - 1);
  localparam logic [15:0] TICK_LAST = 16'(WR_TICKS - 1);

  logic [7:0]  pre_q, pre_d;
  logic [15:0] cnt_q, cnt_d;
  logic        busy_q, busy_d;
  logic        tick;

  // Free-running prescaler: its phase is unrelated to the start,
  // so the delay varies by up to one tick
  always_comb begin
    tick   = (pre_q == PRE_LAST);
    pre_d  = tick ? 8'h00 : pre_q + 8'h01;
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_o = busy_q && tick && (cnt_q == TICK_LAST);
    if (start_i) begin
      busy_d = 1'b1;
      cnt_d  = 16'h0000;
    end else if (busy_q && tick) begin
      cnt_d  = cnt_q + 16'h0001;
      busy_d = !done_o;
    end
  end

  // Register timer state
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pre_q  <= 8'h00;
      cnt_q  <= 16'h0000;
      busy_q <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
    end
  end

endmodule : edac_wr_timer

// ---- core/edac_top.sv ----
`timescale 1ns/100ps
module edac_top #(
  parameter int unsigned WR_TICKS = edac_pkg::WR_TICKS
) (
  input  wire logic       sys_clk_i,       // System clock, 125 MHz
  input  wire logic       rst_n_i,         // Sync reset, active low
  input  wire logic [7:0] sfr_addr_i,      // Special register address
  input  wire logic       sfr_bank_i,      // Bank of the access
  input  wire logic       sfr_wr_i,        // Register write strobe
  input  wire logic [7:0] sfr_wdata_i,     // Register write data
  input  wire logic       sfr_rd_i,        // Register read strobe
  output logic      [7:0] sfr_rdata_o,     // Register read data
  input  wire logic       done_flag_clr_i, // Software clears done flag
  input  wire logic       shared_clr_i,    // Service clears shared flag
  output logic            nv_cycle_done_flag_o, // End-of-write flag
  output logic            shared_irq_flag_o,    // Shared request flag
  output logic            busy_o           // A cycle is in progress
);

  edac_pkg::edac_state_e state_q, state_d;

  logic [5:0] nv_location_index_q, nv_location_index_d;
  logic [7:0] nv_byte_buffer_q, nv_byte_buffer_d;
  logic       write_enable_bit_q, write_enable_bit_d;
  logic       wr_start_q, wr_start_d;
  logic       read_enable_bit_q, read_enable_bit_d;
  logic       rd_start_q, rd_start_d;
  logic [1:0] rd_cnt_q, rd_cnt_d;
  logic [7:0] rdata_q, rdata_d;
  logic       done_q, done_d;
  logic       shared_q, shared_d;
  logic       ctl_wr, idx_wr, buf_wr, wr_go, rd_go, idle;
  logic       timer_done, store_we;
  logic [7:0] store_rdata, rd_mux;

  // Byte array
  edac_store u_store (
    .sys_clk_i (sys_clk_i),
    .we_i      (store_we),
    .re_i      (rd_go),
    .addr_i    (nv_location_index_q),
    .wdata_i   (nv_byte_buffer_q),
    .rdata_o   (store_rdata)
  );

  // Write-cycle delay
  edac_wr_timer #(
    .WR_TICKS (WR_TICKS)
  ) u_timer (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (wr_go),
    .done_o    (timer_done)
  );

  // Access decode and cycle starts
  always_comb begin
    idle   = (state_q == edac_pkg::EDAC_IDLE);
    ctl_wr = sfr_wr_i && (sfr_bank_i == edac_pkg::BANK_CTL)
             && (sfr_addr_i == edac_pkg::CTL_OFS);
    idx_wr = sfr_wr_i && idle && (sfr_addr_i == edac_pkg::IDX_OFS);
    buf_wr = sfr_wr_i && idle && (sfr_addr_i == edac_pkg::BUF_OFS);
    wr_go  = ctl_wr && idle && write_enable_bit_q
             && sfr_wdata_i[edac_pkg::WR_BIT];
    rd_go  = ctl_wr && idle && read_enable_bit_q && !wr_go
             && sfr_wdata_i[edac_pkg::RD_BIT];
    // Write enable dropped mid-cycle suppresses the store write
    store_we = timer_done && (state_q == edac_pkg::EDAC_WRITE)
               && write_enable_bit_q;
  end

  // Register readback, unused bits as zero
  always_comb begin
    rd_mux = 8'h00;
    if (sfr_addr_i == edac_pkg::IDX_OFS) begin
      rd_mux = {2'b00, nv_location_index_q};
    end else if (sfr_addr_i == edac_pkg::BUF_OFS) begin
      rd_mux = nv_byte_buffer_q;
    end else if ((sfr_addr_i == edac_pkg::CTL_OFS)
                 && (sfr_bank_i == edac_pkg::BANK_CTL)) begin
      rd_mux = {4'h0, write_enable_bit_q, wr_start_q,
                read_enable_bit_q, rd_start_q};
    end
  end

  // Next values of the sequencer and registers
  always_comb begin
    state_d             = state_q;
    nv_location_index_d = nv_location_index_q;
    nv_byte_buffer_d    = nv_byte_buffer_q;
    write_enable_bit_d  = write_enable_bit_q;
    read_enable_bit_d   = read_enable_bit_q;
    wr_start_d          = wr_start_q;
    rd_start_d          = rd_start_q;
    rd_cnt_d            = rd_cnt_q;
    rdata_d             = sfr_rd_i ? rd_mux : rdata_q;
    if (idx_wr) begin
      nv_location_index_d = sfr_wdata_i[5:0];
    end
    if (buf_wr) begin
      nv_byte_buffer_d = sfr_wdata_i;
    end
    // Enables follow software; starts are only set by the sequencer below
    if (ctl_wr) begin
      write_enable_bit_d = sfr_wdata_i[edac_pkg::WRITE_ENABLE_BIT_BIT];
      read_enable_bit_d  = sfr_wdata_i[edac_pkg::READ_ENABLE_BIT_BIT];
    end
    case (state_q)
      edac_pkg::EDAC_IDLE: begin
        if (wr_go) begin
          wr_start_d = 1'b1;
          state_d    = edac_pkg::EDAC_WRITE;
        end else if (rd_go) begin
          rd_start_d = 1'b1;
          rd_cnt_d   = 2'b00;
          state_d    = edac_pkg::EDAC_READ;
        end
      end
      edac_pkg::EDAC_READ: begin
        if (rd_cnt_q == edac_pkg::RD_LAST) begin
          rd_start_d       = 1'b0;
          nv_byte_buffer_d = store_rdata;
          state_d          = edac_pkg::EDAC_IDLE;
        end else begin
          rd_cnt_d = rd_cnt_q + 2'b01;
        end
      end
      edac_pkg::EDAC_WRITE: begin
        if (timer_done) begin
          wr_start_d = 1'b0;
          state_d    = edac_pkg::EDAC_IDLE;
        end
      end
      default: begin
        state_d = edac_pkg::EDAC_IDLE;
      end
    endcase
  end

  // End-of-write flags, a set wins over a clear
  always_comb begin
    done_d   = store_we || (done_q && !done_flag_clr_i);
    shared_d = store_we || (shared_q && !shared_clr_i);
  end

  // Register all state
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_q             <= edac_pkg::EDAC_IDLE;
      nv_location_index_q <= edac_pkg::IDX_RST;
      nv_byte_buffer_q    <= edac_pkg::BUF_RST;
      write_enable_bit_q  <= edac_pkg::CTL_RST;
      read_enable_bit_q   <= edac_pkg::CTL_RST;
      wr_start_q          <= edac_pkg::CTL_RST;
      rd_start_q          <= edac_pkg::CTL_RST;
      rd_cnt_q            <= 2'b00;
      rdata_q             <= 8'h00;
      done_q              <= 1'b0;
      shared_q            <= 1'b0;
    end else begin
      state_q             <= state_d;
      nv_location_index_q <= nv_location_index_d;
      nv_byte_buffer_q    <= nv_byte_buffer_d;
      write_enable_bit_q  <= write_enable_bit_d;
      read_enable_bit_q   <= read_enable_bit_d;
      wr_start_q          <= wr_start_d;
      rd_start_q          <= rd_start_d;
      rd_cnt_q            <= rd_cnt_d;
      rdata_q             <= rdata_d;
      done_q              <= done_d;
      shared_q            <= shared_d;
    end
  end

  // Outputs
  assign sfr_rdata_o          = rdata_q;
  assign nv_cycle_done_flag_o = done_q;
  assign shared_irq_flag_o    = shared_q;
  assign busy_o               = !idle;

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence rd_req_s;
    rd_go;
  endsequence

  sequence rd_run_s;
    rd_start_q [*2] ##1 !rd_start_q;
  endsequence

  wr_gate_a: assert property (
    (ctl_wr && sfr_wdata_i[edac_pkg::WR_BIT] && !write_enable_bit_q
     && !wr_start_q) |=> !wr_start_q)
    else $error("write start accepted without write enable");

  rd_gate_a: assert property (
    (ctl_wr && sfr_wdata_i[edac_pkg::RD_BIT] && !read_enable_bit_q
     && !rd_start_q) |=> !rd_start_q)
    else $error("read start accepted without read enable");

  rd_cycle_a: assert property (
    rd_req_s |=> rd_run_s)
    else $error("read cycle length wrong");

  rd_data_a: assert property (
    $fell(rd_start_q) |-> (nv_byte_buffer_q == $past(store_rdata)))
    else $error("fetched byte not in buffer");

  wr_end_a: assert property (
    store_we |=> (!wr_start_q && done_q && shared_q && idle))
    else $error("write end not reported");

  wr_only_a: assert property (
    store_we |-> (wr_start_q && write_enable_bit_q
                  && (state_q == edac_pkg::EDAC_WRITE)))
    else $error("store written outside write cycle");

  buf_hold_a: assert property (
    (idle && !buf_wr && !store_we) |=> $stable(nv_byte_buffer_q))
    else $error("buffer changed without an operation");

  busy_ignore_a: assert property (
    (!idle && sfr_wr_i) |=> ($stable(nv_location_index_q)
                             && ($stable(nv_byte_buffer_q)
                                 || $fell(rd_start_q))))
    else $error("index or buffer written while busy");

  idx_read_a: assert property (
    (sfr_rd_i && sfr_addr_i == edac_pkg::IDX_OFS)
    |=> (sfr_rdata_o[7:6] == 2'b00)
        && (sfr_rdata_o[5:0] == $past(nv_location_index_q)))
    else $error("index readback wrong");

  ctl_read_a: assert property (
    (sfr_rd_i && sfr_bank_i && sfr_addr_i == edac_pkg::CTL_OFS)
    |=> (sfr_rdata_o == {4'h0, $past(write_enable_bit_q),
                         $past(wr_start_q), $past(read_enable_bit_q),
                         $past(rd_start_q)}))
    else $error("control readback wrong");

  flag_set_a: assert property (
    (store_we && done_flag_clr_i && shared_clr_i)
    |=> (done_q && shared_q))
    else $error("clear beat a set of the flags");

  rst_clear_a: assert property (
    @(posedge sys_clk_i) disable iff (1'b0)
    !rst_n_i |=> (!write_enable_bit_q && !wr_start_q && idle))
    else $error("reset left write enabled");

  // Write request and the running write that follows it
  sequence wr_req_s;
    wr_go;
  endsequence

  sequence wr_busy_s;
    wr_start_q && (state_q == edac_pkg::EDAC_WRITE);
  endsequence

  wr_start_a: assert property (
    wr_req_s |=> wr_busy_s)
    else $error("write start did not begin a cycle");

  wr_hold_a: assert property (
    ((state_q == edac_pkg::EDAC_WRITE) && !timer_done)
    |=> wr_start_q)
    else $error("write start dropped before cycle end");

  one_start_a: assert property (
    !(wr_start_q && rd_start_q))
    else $error("read and write cycles both running");

  rd_busy_a: assert property (
    rd_start_q |-> (state_q == edac_pkg::EDAC_READ))
    else $error("read start high outside a read cycle");

  // Flags are sticky until their own clear
  done_keep_a: assert property (
    (done_q && !done_flag_clr_i) |=> done_q)
    else $error("done flag lost without a clear");

  shared_keep_a: assert property (
    (shared_q && !shared_clr_i) |=> shared_q)
    else $error("shared flag lost without a clear");

  done_clr_a: assert property (
    (done_flag_clr_i && !store_we) |=> !done_q)
    else $error("done flag clear ignored");

  shared_clr_a: assert property (
    (shared_clr_i && !store_we) |=> !shared_q)
    else $error("shared flag clear ignored");

  done_only_a: assert property (
    (!store_we && !done_q) |=> !done_q)
    else $error("done flag rose without a write end");

  rdata_hold_a: assert property (
    !sfr_rd_i |=> $stable(sfr_rdata_o))
    else $error("read data changed without a read");

endmodule : edac_top

// ---- test/edac_cpu_model.sv ----
`timescale 1ns/100ps
module edac_cpu_model (
  input  wire logic       sys_clk_i,   // System clock
  input  wire logic [7:0] sfr_rdata_i, // Read data
  output logic      [7:0] sfr_addr_o,  // Register address
  output logic            sfr_bank_o,  // Access bank
  output logic            sfr_wr_o,    // Write strobe
  output logic      [7:0] sfr_wdata_o, // Write data
  output logic            sfr_rd_o     // Read strobe
);
  // Bus idle from time zero
  initial begin
    sfr_addr_o  = 8'h00;
    sfr_bank_o  = 1'b0;
    sfr_wr_o    = 1'b0;
    sfr_wdata_o = 8'h00;
    sfr_rd_o    = 1'b0;
  end
  // One write, held across its taking edge
  task automatic wr(input logic b, input logic [7:0] a, d);
    @(negedge sys_clk_i);
    sfr_bank_o  = b;
    sfr_addr_o  = a;
    sfr_wdata_o = d;
    sfr_wr_o    = 1'b1;
    @(negedge sys_clk_i);
    sfr_wr_o    = 1'b0;
    sfr_wdata_o = ~d; // Released data stops showing the byte
  endtask : wr
  // One read, data taken once settled
  task automatic rd(input logic b, input logic [7:0] a,
                    output logic [7:0] d);
    @(negedge sys_clk_i);
    sfr_bank_o = b;
    sfr_addr_o = a;
    sfr_rd_o   = 1'b1;
    @(negedge sys_clk_i);
    sfr_rd_o = 1'b0;
    @(negedge sys_clk_i);
    d = sfr_rdata_i;
  endtask : rd
  // Enable then start in the next cycle, one start bit only
  task automatic go(input logic [7:0] en);
    @(negedge sys_clk_i);
    sfr_bank_o  = edac_pkg::BANK_CTL;
    sfr_addr_o  = edac_pkg::CTL_OFS;
    sfr_wdata_o = en;
    sfr_wr_o    = 1'b1;
    @(negedge sys_clk_i);
    sfr_wdata_o = en | (en >> 1);
    @(negedge sys_clk_i);
    sfr_wr_o    = 1'b0;
  endtask : go
endmodule : edac_cpu_model

// ---- test/edac_top_tb.sv ----
`timescale 1ns/100ps
module edac_top_tb;
  logic       sys_clk_i   = 1'b0; // System clock
  logic       rst_n_i     = 1'b0; // Reset, active low
  logic       done_clr    = 1'b0; // Done flag clear
  logic       shared_clr  = 1'b0; // Shared flag clear
  logic [7:0] sfr_addr;           // Register address
  logic       sfr_bank;           // Access bank
  logic       sfr_wr;             // Write strobe
  logic [7:0] sfr_wdata;          // Write data
  logic       sfr_rd;             // Read strobe
  logic [7:0] sfr_rdata;          // Read data
  logic       done;               // End-of-write flag
  logic       shared;             // Shared flag
  logic       busy;               // Cycle running
  int         fails = 0;
  int         total_checks = 0;
  int         mem [64];           // Store model
  int         bufm = 0;           // Buffer model

  // Clock, 8 ns period
  always #4 sys_clk_i = ~sys_clk_i;

  edac_top #(.WR_TICKS(3)) u_edac_top (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr),
    .sfr_bank_i(sfr_bank), .sfr_wr_i(sfr_wr), .sfr_wdata_i(sfr_wdata),
    .sfr_rd_i(sfr_rd), .sfr_rdata_o(sfr_rdata),
    .done_flag_clr_i(done_clr), .shared_clr_i(shared_clr),
    .nv_cycle_done_flag_o(done), .shared_irq_flag_o(shared),
    .busy_o(busy));

  edac_cpu_model u_edac_cpu_model (
    .sys_clk_i(sys_clk_i), .sfr_rdata_i(sfr_rdata),
    .sfr_addr_o(sfr_addr), .sfr_bank_o(sfr_bank), .sfr_wr_o(sfr_wr),
    .sfr_wdata_o(sfr_wdata), .sfr_rd_o(sfr_rd));

  // Compare and count
  task automatic chk(input logic [7:0] s, input int e);
    total_checks++;
    if (s !== 8'(e)) begin
      fails++;
      $display("MISMATCH %0t seen %h exp %h", $time, s, 8'(e));
    end
  endtask : chk

  // Read a register and compare
  task automatic reg_is(input logic b, input logic [7:0] a, input int e);
    logic [7:0] d;
    u_edac_cpu_model.rd(b, a, d);
    chk(d, e);
  endtask : reg_is

  // Pulse one flag clear for a cycle
  task automatic clr(input bit sh);
    @(negedge sys_clk_i);
    if (sh) shared_clr = 1'b1;
    else done_clr = 1'b1;
    @(negedge sys_clk_i);
    shared_clr = 1'b0;
    done_clr   = 1'b0;
  endtask : clr

  // Poll write start until hardware clears it
  task automatic poll_wr(output logic [7:0] d);
    int i;
    d = 8'h04;
    for (i = 0; i < 300 && d[2] === 1'b1; i++)
      u_edac_cpu_model.rd(1'b1, edac_pkg::CTL_OFS, d);
  endtask : poll_wr

  // Commit one byte, poking index and buffer while busy
  task automatic put(input int a, input int v);
    logic [7:0] d;
    u_edac_cpu_model.wr(1'b0, edac_pkg::IDX_OFS, 8'(a));
    u_edac_cpu_model.wr(1'b0, edac_pkg::BUF_OFS, 8'(v));
    bufm = v;
    u_edac_cpu_model.go(8'h08);
    chk({7'h00, busy}, 1);
    u_edac_cpu_model.wr(1'b0, edac_pkg::BUF_OFS, 8'($urandom));
    u_edac_cpu_model.wr(1'b0, edac_pkg::IDX_OFS, 8'($urandom));
    poll_wr(d);
    chk(d, 8'h08);
    mem[a] = v;
    chk({7'h00, done}, 1);
    chk({7'h00, shared}, 1);
    clr(1'b0);
    chk({7'h00, done}, 0);
    chk({7'h00, shared}, 1);
    clr(1'b1);
    chk({7'h00, shared}, 0);
    reg_is(1'b0, edac_pkg::IDX_OFS, a);
    reg_is(1'b0, edac_pkg::BUF_OFS, v);
  endtask : put

  // Fetch one byte and check the buffer
  task automatic get(input int a);
    u_edac_cpu_model.wr(1'b0, edac_pkg::IDX_OFS, 8'(a));
    u_edac_cpu_model.go(8'h02);
    chk({7'h00, busy}, 1);
    // Poke the buffer in the last read cycle
    u_edac_cpu_model.wr(1'b0, edac_pkg::BUF_OFS, 8'($urandom));
    chk({7'h00, busy}, 0);
    bufm = mem[a];
    reg_is(1'b0, edac_pkg::BUF_OFS, bufm);
    reg_is(1'b1, edac_pkg::CTL_OFS, 8'h02);
    reg_is(1'b0, edac_pkg::BUF_OFS, bufm);
  endtask : get

  // Print counts and verdict, then stop
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fails++;
    give_verdict();
  end

  // Main sequence
  initial begin
    int q[$];
    logic [7:0] d;
    void'($urandom(32'h1acc_7fbb));
    repeat (4) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    reg_is(1'b1, edac_pkg::CTL_OFS, 0);
    reg_is(1'b0, edac_pkg::IDX_OFS, 0);
    reg_is(1'b0, edac_pkg::CTL_OFS, 0);
    $display("test reset done");
    u_edac_cpu_model.wr(1'b0, edac_pkg::IDX_OFS, 8'hFF);
    reg_is(1'b0, edac_pkg::IDX_OFS, 8'h3F);
    $display("test index done");
    q = {0, 63};
    repeat (4) q.push_back($urandom_range(1, 62));
    foreach (q[k]) put(q[k], $urandom_range(0, 255));
    $display("test write done");
    // Reset in mid-run with write enable still set
    @(negedge sys_clk_i);
    rst_n_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    reg_is(1'b1, edac_pkg::CTL_OFS, 0);
    $display("test rerun reset done");
    u_edac_cpu_model.wr(1'b1, edac_pkg::CTL_OFS, 8'h00);
    u_edac_cpu_model.wr(1'b0, edac_pkg::BUF_OFS, 8'h5A);
    u_edac_cpu_model.wr(1'b1, edac_pkg::CTL_OFS, 8'h04);
    chk({7'h00, busy}, 0);
    u_edac_cpu_model.wr(1'b1, edac_pkg::CTL_OFS, 8'h01);
    chk({7'h00, busy}, 0);
    reg_is(1'b1, edac_pkg::CTL_OFS, 0);
    reg_is(1'b0, edac_pkg::BUF_OFS, 8'h5A);
    $display("test guard done");
    // Drop write enable mid-write: location 0 must keep its byte
    u_edac_cpu_model.go(8'h08);
    u_edac_cpu_model.wr(1'b1, edac_pkg::CTL_OFS, 8'h00);
    poll_wr(d);
    chk(d, 8'h00);
    $display("test abort done");
    foreach (q[k]) get(q[q.size() - 1 - k]);
    $display("test read done");
    give_verdict();
  end
endmodule : edac_top_tb
